/* File: hw/mmc_pkg.sv */
/*
 * Package for the memory mode select block: address map, sizes, carriers.
 * Assumes a 32-bit word-addressed fetch path and a 40 MHz system clock.
 */
package mmc_pkg;
   // Word address width; the 144 kB unified range needs 36 K words
   localparam int unsigned AW = 24;
   // Sizes in 32-bit words
   localparam logic [AW-1:0] DATA_RAM_WORDS  = 24'h008000; // 128 kB
   localparam logic [AW-1:0] CACHE_RAM_WORDS = 24'h001000; // 16 kB
   localparam logic [AW-1:0] UNIFIED_WORDS   = 24'h009000; // 144 kB
   // Region bases (word addresses)
   localparam logic [AW-1:0] RAM_BASE   = 24'h200000;
   localparam logic [AW-1:0] OTP_BASE   = 24'h100000;
   localparam logic [AW-1:0] OTP_WORDS  = 24'h004000;     // 64 kB
   localparam logic [AW-1:0] FLASH_BASE = 24'h040000;
   localparam logic [AW-1:0] FLASH_WORDS = 24'h040000;    // 8 Mbit
   // Reset value of the latched mode
   localparam logic MODE_RST = 1'b0;

   typedef enum logic [1:0] {
      MMC_IDLE  = 2'b00,
      MMC_READ  = 2'b01,
      MMC_WRITE = 2'b10,
      MMC_RUN   = 2'b11
   } mmc_state_t;

   // Request of one word from a master or to a target
   typedef struct packed {
      logic          valid;
      logic          write;
      logic [AW-1:0] addr;
      logic [31:0]   wdata;
   } mmc_req_t;

   // Target selector for a decoded address
   typedef struct packed {
      logic          to_nvm;   // OTP or flash
      logic          to_ram;   // unified/data RAM
      logic          cachable; // goes through cache controller
      logic [AW-1:0] ram_idx;  // word index into the unified RAM
   } mmc_route_t;
endpackage

/* File: hw/mmc_decode.sv */
/*
 * Address decoder for the memory mode select block.
 * Assumes addresses are word addresses and mode bits are stable.
 */
`timescale 1ns/1ps
`default_nettype none
module mmc_decode
(
   input  wire logic                     mirrored,
   input  wire logic                     cache_otp,
   input  wire logic                     cache_flash,
   input  wire logic [mmc_pkg::AW-1:0]   addr,
   output mmc_pkg::mmc_route_t           route
);
   // Range check shared by every region
   function automatic logic in_range(input logic [mmc_pkg::AW-1:0] a,
                                     input logic [mmc_pkg::AW-1:0] base,
                                     input logic [mmc_pkg::AW-1:0] len);
      in_range = (a >= base) && (a - base < len);
   endfunction

   logic is_otp;
   logic is_flash;
   logic [mmc_pkg::AW-1:0] ram_len;

   // Cache array only joins the RAM range while mirrored
   assign ram_len = mirrored ? mmc_pkg::UNIFIED_WORDS : mmc_pkg::DATA_RAM_WORDS;
   assign is_otp   = in_range(addr, mmc_pkg::OTP_BASE, mmc_pkg::OTP_WORDS);
   assign is_flash = in_range(addr, mmc_pkg::FLASH_BASE, mmc_pkg::FLASH_WORDS);

   // One contiguous RAM window, tag RAM never mapped
   always_comb
   begin
      route.to_ram   = in_range(addr, mmc_pkg::RAM_BASE, ram_len);
      route.ram_idx  = addr - mmc_pkg::RAM_BASE;
      route.to_nvm   = is_otp | is_flash;
      // Data RAM never cachable; mirrored never cachable
      route.cachable = !mirrored && ((is_otp && cache_otp) || (is_flash && cache_flash));
   end
endmodule
`default_nettype wire

/* File: hw/mmc_top.sv */
/*
 * Memory mode select: mirrored (copy code to unified RAM) or cached execution.
 * Assumes NVM and RAM answer each request with a ready pulse, after any number of wait cycles.
 * Assumes the straps are settled before reset is released; they are not
 * synchronised, since they may only move while the block sits in reset.
 * Assumes image_words stays put from reset release until the copy ends.
 * Assumes a wake pulse lasts one clock; it is ignored in cached mode.
 */
// How it works
// - Mirrored mode copies image at every boot/wake
// - After copy CPU fetches from unified RAM
// - Mirrored mode fully bypasses the instruction cache
// - All RAM except tag RAM contiguous
// - Cache array extends data RAM to 144 kB
// - Cached mode fetches NVM through cache controller
// - Cacheable region covers OTP, flash or both
// - Data RAM fetches bypass cache in cached mode
// - Copy length counted in 32-bit words
`timescale 1ns/1ps
`default_nettype none
module mmc_top
(
   input  wire logic                     clk,
   input  wire logic                     reset_n,
   input  wire logic                     mode_cached_strap,
   input  wire logic                     cache_otp_strap,
   input  wire logic                     cache_flash_strap,
   input  wire logic                     mirror_from_otp,
   input  wire logic [mmc_pkg::AW-1:0]   image_words,
   input  wire logic                     wake_pulse,
   input  wire mmc_pkg::mmc_req_t        cpu_req,
   output logic                          cpu_ready,
   output logic [31:0]                   cpu_rdata,
   output logic                          cpu_hold,
   output mmc_pkg::mmc_req_t             cache_req,
   input  wire logic                     cache_ready,
   input  wire logic [31:0]              cache_rdata,
   output mmc_pkg::mmc_req_t             nvm_req,
   input  wire logic                     nvm_ready,
   input  wire logic [31:0]              nvm_rdata,
   output mmc_pkg::mmc_req_t             ram_req,
   input  wire logic                     ram_ready,
   input  wire logic [31:0]              ram_rdata,
   output logic                          mirror_busy
);
   ///////////////////////////////////////////////////////////////////////////
   logic                      latched_reg;
   logic                      mirrored_reg;
   logic                      c_otp_reg;
   logic                      c_flash_reg;
   mmc_pkg::mmc_state_t       state_reg;
   mmc_pkg::mmc_state_t       state_next;
   logic [mmc_pkg::AW-1:0]    count_reg;
   logic [31:0]               word_reg;
   mmc_pkg::mmc_route_t       route;
   logic [31:0]               rdata_next;
   logic                      ready_next;
   logic [mmc_pkg::AW-1:0]    copy_len;
   logic                      copy_last;

   // Straps sampled once after reset release; async reset loads constants only
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         latched_reg  <= 1'b0;
         mirrored_reg <= !mmc_pkg::MODE_RST;
         c_otp_reg    <= 1'b0;
         c_flash_reg  <= 1'b0;
      end
      else if (!latched_reg)
      begin
         latched_reg  <= 1'b1;
         mirrored_reg <= !mode_cached_strap;
         c_otp_reg    <= cache_otp_strap;
         c_flash_reg  <= cache_flash_strap;
      end
   end

   mmc_decode u_dec
   (
      .mirrored    (mirrored_reg),
      .cache_otp   (c_otp_reg),
      .cache_flash (c_flash_reg),
      .addr        (cpu_req.addr),
      .route       (route)
   );

   ///////////////////////////////////////////////////////////////////////////
   // Copy length clipped to the unified RAM; an oversized length would
   // otherwise wrap the write index and overwrite the start of the image
   assign copy_len  = (image_words > mmc_pkg::UNIFIED_WORDS) ? mmc_pkg::UNIFIED_WORDS
                                                             : image_words;
   // Last word of the image is being written
   assign copy_last = (count_reg + 1'b1 == copy_len);

   // Copy sequencer: read NVM word, write RAM word, repeat copy_len times
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         mmc_pkg::MMC_IDLE:
            if (latched_reg)
               state_next = (mirrored_reg && image_words != '0) ? mmc_pkg::MMC_READ
                                                                : mmc_pkg::MMC_RUN;
         mmc_pkg::MMC_READ:
            if (nvm_ready)
               state_next = mmc_pkg::MMC_WRITE;
         mmc_pkg::MMC_WRITE:
            if (ram_ready)
               state_next = copy_last ? mmc_pkg::MMC_RUN : mmc_pkg::MMC_READ;
         mmc_pkg::MMC_RUN:
            if (wake_pulse && mirrored_reg)
               state_next = mmc_pkg::MMC_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         state_reg <= mmc_pkg::MMC_IDLE;
      else
         state_reg <= state_next;
   end

   // Word counter, one per 32-bit word moved
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         count_reg <= '0;
      else if (state_reg == mmc_pkg::MMC_IDLE)
         count_reg <= '0;
      else if (state_reg == mmc_pkg::MMC_WRITE && ram_ready)
         count_reg <= count_reg + 1'b1;
   end

   // Holding register between read and write
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         word_reg <= '0;
      else if (state_reg == mmc_pkg::MMC_READ && nvm_ready)
         word_reg <= nvm_rdata;
   end

   // CPU stalls until copy done; fetches start only in RUN
   assign cpu_hold    = (state_reg != mmc_pkg::MMC_RUN);
   assign mirror_busy = (state_reg == mmc_pkg::MMC_READ) || (state_reg == mmc_pkg::MMC_WRITE);

   ///////////////////////////////////////////////////////////////////////////
   // Request steering; copy engine owns NVM and RAM while busy
   always_comb
   begin
      logic run;
      run       = (state_reg == mmc_pkg::MMC_RUN) && cpu_req.valid;
      cache_req = '0;
      nvm_req   = '0;
      ram_req   = '0;
      if (state_reg == mmc_pkg::MMC_READ)
      begin
         nvm_req.valid = 1'b1;
         nvm_req.addr  = (mirror_from_otp ? mmc_pkg::OTP_BASE : mmc_pkg::FLASH_BASE)
                         + count_reg;
      end
      else if (state_reg == mmc_pkg::MMC_WRITE)
      begin
         ram_req.valid = 1'b1;
         ram_req.write = 1'b1;
         ram_req.addr  = count_reg;
         ram_req.wdata = word_reg;
      end
      else if (run && route.cachable)
         cache_req = cpu_req;
      else if (run && route.to_ram)
      begin
         ram_req       = cpu_req;
         ram_req.addr  = route.ram_idx;
      end
      // Cached mode NVM outside the cached region goes straight to NVM
      else if (run && route.to_nvm && !mirrored_reg)
         nvm_req = cpu_req;
   end

   // Answer mux; unmapped addresses answer at once with zero
   always_comb
   begin
      rdata_next = '0;
      ready_next = 1'b0;
      if (cache_req.valid)
      begin
         ready_next = cache_ready;
         rdata_next = cache_rdata;
      end
      else if (ram_req.valid && state_reg == mmc_pkg::MMC_RUN)
      begin
         ready_next = ram_ready;
         rdata_next = ram_rdata;
      end
      else if (nvm_req.valid && state_reg == mmc_pkg::MMC_RUN)
      begin
         ready_next = nvm_ready;
         rdata_next = nvm_rdata;
      end
      else if (state_reg == mmc_pkg::MMC_RUN && cpu_req.valid)
         ready_next = 1'b1; // Unmapped: no hang
   end

   assign cpu_ready = ready_next;

   // Data registered for a clean output; valid one cycle after cpu_ready
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         cpu_rdata <= '0;
      else if (ready_next)
         cpu_rdata <= rdata_next;
   end
endmodule
`default_nettype wire

/* File: verification/mmc_props.sv */
/* Checker on the mmc_top ports.
   Assumes the straps only move while reset is held. */
`timescale 1ns/1ps
`default_nettype none
module mmc_props
(
   input wire logic              clk,
   input wire logic              reset_n,
   input wire logic              mode_cached_strap,
   input wire logic              cache_otp_strap,
   input wire logic              cache_flash_strap,
   input wire mmc_pkg::mmc_req_t cpu_req,
   input wire logic              cpu_ready,
   input wire logic [31:0]       cpu_rdata,
   input wire logic              cpu_hold,
   input wire mmc_pkg::mmc_req_t cache_req,
   input wire mmc_pkg::mmc_req_t nvm_req,
   input wire logic              nvm_ready,
   input wire logic [31:0]       nvm_rdata,
   input wire mmc_pkg::mmc_req_t ram_req,
   input wire logic              mirror_busy
);
   logic        go, otp_a, fl_a, m;
   logic [23:0] off;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////
   // Region hits of the CPU request; offsets wrap, so one compare per range
   assign m     = mode_cached_strap;
   assign go    = cpu_req.valid && !cpu_hold;
   assign off   = cpu_req.addr - mmc_pkg::RAM_BASE;
   assign otp_a = cpu_req.addr - mmc_pkg::OTP_BASE < mmc_pkg::OTP_WORDS;
   assign fl_a  = cpu_req.addr - mmc_pkg::FLASH_BASE < mmc_pkg::FLASH_WORDS;
   // Copy step: a word read from NVM is written next cycle
   sequence s_copy_rd; mirror_busy && nvm_req.valid && nvm_ready; endsequence
   property p_copy_wr;
      s_copy_rd |=> ram_req.valid && ram_req.write && ram_req.wdata == $past(nvm_rdata);
   endproperty
   a_copy_wr: assert property (p_copy_wr) else $error("copy word lost");
   property p_hold; mirror_busy |-> cpu_hold && !cpu_ready; endproperty
   a_hold: assert property (p_hold) else $error("CPU served during copy");
   property p_no_cache; !m |-> !cache_req.valid; endproperty
   a_no_cache: assert property (p_no_cache) else $error("cache used when mirrored");
   property p_nvm_gone; go && !m && otp_a |-> cpu_ready && !nvm_req.valid ##1 cpu_rdata == 0;
   endproperty
   a_nvm_gone: assert property (p_nvm_gone) else $error("NVM fetch when mirrored");
   property p_cached; go && m && (otp_a && cache_otp_strap || fl_a && cache_flash_strap)
      |-> cache_req.valid && cache_req.addr == cpu_req.addr; endproperty
   a_cached: assert property (p_cached) else $error("NVM fetch missed cache");
   property p_bypass; go && m && off < mmc_pkg::DATA_RAM_WORDS
      |-> ram_req.valid && !cache_req.valid && ram_req.addr == off; endproperty
   a_bypass: assert property (p_bypass) else $error("data RAM through cache");
   property p_top; go && !m && off == mmc_pkg::UNIFIED_WORDS - 24'h1
      |-> ram_req.valid && ram_req.addr == off; endproperty
   a_top: assert property (p_top) else $error("unified top word lost");
   property p_no_copy; m |-> !mirror_busy; endproperty
   a_no_copy: assert property (p_no_copy) else $error("copy in cached mode");
endmodule
`default_nettype wire

/* File: verification/mmc_far.sv */
/* Far side: NVM, cache controller and RAM cells, one word each.
   Assumes one request at a time; slow adds two wait states. */
`timescale 1ns/1ps
`default_nettype none
module mmc_far
(
   input  wire logic              clk,
   input  wire logic              slow,
   input  wire mmc_pkg::mmc_req_t nvm_req,
   input  wire mmc_pkg::mmc_req_t cache_req,
   input  wire mmc_pkg::mmc_req_t ram_req,
   output logic                   nvm_ready,
   output logic [31:0]            nvm_rdata,
   output logic                   cache_ready,
   output logic [31:0]            cache_rdata,
   output logic                   ram_ready,
   output logic [31:0]            ram_rdata
);
   logic [1:0]  wt = 2'h0;
   logic        go;
   logic [31:0] mem [64];
   ////////////////////////////////////////////////////////////
   // Wait states, counted while a request stands
   always_ff @(posedge clk)
      wt <= (nvm_req.valid || cache_req.valid || ram_req.valid) && !go ? wt + 2'h1 : 2'h0;
   assign go          = !slow || wt == 2'h2;
   assign nvm_ready   = nvm_req.valid && go;
   assign cache_ready = cache_req.valid && go;
   assign ram_ready   = ram_req.valid && go;
   // Data is inverted outside ready, so a stale word never passes
   assign nvm_rdata   = {8'ha5, nvm_req.addr} ^ {32{!nvm_ready}};
   assign cache_rdata = {8'hc3, cache_req.addr} ^ {32{!cache_ready}};
   assign ram_rdata   = mem[ram_req.addr[5:0]] ^ {32{!ram_ready}};
   always_ff @(posedge clk)
      if (ram_ready && ram_req.write)
         mem[ram_req.addr[5:0]] <= ram_req.wdata;
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
/* Bench for mmc_top: boot and wake copy, unified RAM, cached paths.
   Assumes mmc_far as the far side and mmc_props bound to mmc_top. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
   $display("CHECK FAILED %0t got %h", $time, a); end end
module tb_top;
   logic              clk = 1'b0, reset_n = 1'b0, slow = 1'b0, wake_pulse = 1'b0;
   logic              mode_cached_strap = 1'b0, cache_otp_strap = 1'b0;
   logic              cache_flash_strap = 1'b0, mirror_from_otp = 1'b1;
   logic [23:0]       image_words = 24'h0;
   logic [31:0]       q, cpu_rdata, nvm_rdata, cache_rdata, ram_rdata;
   logic              cpu_ready, cpu_hold, mirror_busy, nvm_ready, cache_ready, ram_ready;
   mmc_pkg::mmc_req_t cpu_req = '0, cache_req, nvm_req, ram_req;
   int                num_errors = 0, check_count = 0, cycles = 0;
   always #12.5 clk = ~clk;
   mmc_top dut_u (.clk, .reset_n, .mode_cached_strap, .cache_otp_strap, .cache_flash_strap,
      .mirror_from_otp, .image_words, .wake_pulse, .cpu_req, .cpu_ready, .cpu_rdata, .cpu_hold,
      .cache_req, .cache_ready, .cache_rdata, .nvm_req, .nvm_ready, .nvm_rdata, .ram_req,
      .ram_ready, .ram_rdata, .mirror_busy);
   mmc_far far_u (.clk, .slow, .nvm_req, .cache_req, .ram_req, .nvm_ready, .nvm_rdata,
      .cache_ready, .cache_rdata, .ram_ready, .ram_rdata);
   ////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Bounded wait for the end of the copy
   task automatic run_wait();
      for (int n = 0; n < 400 && cpu_hold !== 1'b0; n++)
         @(posedge clk) #1;
      `CHK(cpu_hold, 1'b0)
   endtask
   // Straps only move under reset
   task automatic do_reset(input logic [2:0] s, input logic [23:0] w);
      {mode_cached_strap, cache_otp_strap, cache_flash_strap} = s;
      image_words = w;
      reset_n = 1'b0;
      repeat (5) @(posedge clk);
      #1;
      reset_n = 1'b1;
      repeat (2) @(posedge clk) #1;
      run_wait();
   endtask
   // One CPU word, held until ready; data is read the cycle after
   task automatic acc(input logic w, input logic [23:0] a, input logic [31:0] d);
      @(posedge clk) #1;
      cpu_req = '{1'b1, w, a, d};
      #1;
      for (int n = 0; n < 50 && cpu_ready !== 1'b1; n++)
         @(posedge clk) #1;
      @(posedge clk) #1;
      cpu_req.valid = 1'b0;
      q = cpu_rdata;
   endtask
   task automatic t_mirror();
      do_reset(3'h0, 24'h4);
      for (int i = 0; i < 5; i++)
         `CHK(far_u.mem[i] === {8'ha5, mmc_pkg::OTP_BASE + 24'(i)}, i < 4)
      acc(1'b0, mmc_pkg::RAM_BASE + 24'h2, 32'h0);
      `CHK(q, {8'ha5, mmc_pkg::OTP_BASE + 24'h2})
      acc(1'b1, mmc_pkg::RAM_BASE + 24'h8fff, 32'h600dcafe);
      `CHK(far_u.mem[63], 32'h600dcafe)
      acc(1'b0, mmc_pkg::OTP_BASE, 32'h0);
      `CHK(q, 32'h0)
      $display("t_mirror done");
   endtask
   // Wake restarts the copy, from flash with wait states
   task automatic t_wake();
      slow = 1'b1;
      mirror_from_otp = 1'b0;
      image_words = 24'h2;
      wake_pulse = 1'b1;
      @(posedge clk) #1;
      wake_pulse = 1'b0;
      `CHK(cpu_hold, 1'b1)
      @(posedge clk) #1;
      `CHK(mirror_busy, 1'b1)
      run_wait();
      `CHK(far_u.mem[1], {8'ha5, mmc_pkg::FLASH_BASE + 24'h1})
      slow = 1'b0;
      $display("t_wake done");
   endtask
   task automatic t_cached();
      mirror_from_otp = 1'b1; // A stray copy would now bring OTP words
      do_reset(3'h6, 24'h4);
      `CHK(far_u.mem[0], {8'ha5, mmc_pkg::FLASH_BASE})
      acc(1'b0, mmc_pkg::OTP_BASE + 24'h5, 32'h0);
      `CHK(q, {8'hc3, mmc_pkg::OTP_BASE + 24'h5})
      acc(1'b1, mmc_pkg::RAM_BASE + 24'h1, 32'h12345678);
      acc(1'b0, mmc_pkg::RAM_BASE + 24'h1, 32'h0);
      `CHK(q, 32'h12345678)
      do_reset(3'h5, 24'h0);
      acc(1'b0, mmc_pkg::FLASH_BASE + 24'h3, 32'h0);
      `CHK(q, {8'hc3, mmc_pkg::FLASH_BASE + 24'h3})
      acc(1'b0, mmc_pkg::OTP_BASE + 24'h7, 32'h0);
      `CHK(q, {8'ha5, mmc_pkg::OTP_BASE + 24'h7})
      acc(1'b0, mmc_pkg::RAM_BASE + mmc_pkg::DATA_RAM_WORDS, 32'h0);
      `CHK(q, 32'h0)
      $display("t_cached done");
   endtask
   // Hang guard, far above the fewer than one hundred cycles needed
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         num_errors++;
         end_of_test();
      end
   end
   initial
   begin
      t_mirror();
      t_wake();
      t_cached();
      end_of_test();
   end
endmodule
bind mmc_top mmc_props props_u (.clk, .reset_n, .mode_cached_strap, .cache_otp_strap,
   .cache_flash_strap, .cpu_req, .cpu_ready, .cpu_rdata, .cpu_hold, .cache_req, .nvm_req,
   .nvm_ready, .nvm_rdata, .ram_req, .mirror_busy);
`default_nettype wire
